// ===== gdi_core.sv
// device-side instrument bus interface with axi4-lite registers
//
// Decided for this implementation: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "gdi_defines.svh"
////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// [RULE1] detect listen or talk addressing and show matching readout indicator
// [RULE2] serial poll enable then talk returns status byte; disable ends it
// [RULE3] primary address comes from five rear switches, live after change
// [RULE4] only addresses 0 through 30 are usable; 31 never matches
// [RULE5] with line feed selected, a lone line feed ends a message
// [RULE6] talk-only: each return_local_button press requests settings response
// [RULE7] listen-only: always a listener, takes every bus message; the code stores data bytes only while ren is asserted
// [RULE8] interface clear unaddresses the device and drops listen indicator
// [RULE9] data executed only while remote enable held; release returns local
// [RULE10] service request after power-up and at enabled end of sweep
// [RULE11] identity_query answer starts with fixed prefix, sent when talking
// [RULE12] local lockout disables programmable front-panel controls
// [RULE13] go-to-local re-enables all front-panel controls
// [RULE14] group execute trigger aborts sweep and re-arms trigger
// [RULE15] selected or universal device clear empties output and pending query
module gdi_core
(
   input logic aclk,
   input logic aresetn,
   input logic [7:0] awaddr,
   input logic awvalid,
   output logic awready,
   input logic [31:0] wdata,
   input logic [3:0] wstrb,
   input logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input logic bready,
   input logic [7:0] araddr,
   input logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input logic rready,
   input gdi_pkg::gdi_bus_in_t bus_i,
   output gdi_pkg::gdi_bus_drv_t bus_o,
   output gdi_pkg::gdi_bus_drv_t bus_oe,
   input gdi_pkg::gdi_sw_t sw_i,
   input logic sweep_end,
   output logic listen_ind,
   output logic talk_ind,
   output logic remote,
   output logic panel_lock,
   output logic sweep_rearm,
   output logic irq
);
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and decoded levels
   logic [23:0] sync_q;
   gdi_pkg::gdi_bus_in_t bin;
   gdi_pkg::gdi_sw_t sw;
   logic atn, ifc, ren, dav, nrfd, ndac, eoi, addr_ok;

   gdi_sync #(.W(24), .INIT({15'h7fff, 9'h000})) u_sync
   (
      .aclk(aclk),
      .aresetn(aresetn),
      .d({bus_i, sw_i}),
      .q(sync_q)
   );

   assign bin = sync_q[23:9];
   assign sw = sync_q[8:0];
   assign atn = ~bin.atn_n;
   assign ifc = ~bin.ifc_n;
   assign ren = ~bin.ren_n;
   assign dav = ~bin.dav_n;
   assign nrfd = ~bin.nrfd_n;
   assign ndac = ~bin.ndac_n;
   assign eoi = ~bin.eoi_n;
   assign addr_ok = sw.addr != `GDI_ADDR_NONE; // [RULE4]

   function automatic logic reg_hit(input logic [7:0] a);
      reg_hit = a inside {`GDI_OFS_CTRL, `GDI_OFS_STAT, `GDI_OFS_TXD, `GDI_OFS_RXD, `GDI_OFS_SPOLL,
                          `GDI_OFS_IRQ_STAT, `GDI_OFS_IRQ_MASK};
   endfunction : reg_hit

   function automatic logic [7:0] id_char(input logic [2:0] i);
      logic [63:0] p;
      p = `GDI_ID_PREFIX;
      id_char = p[63 - 8 * i -: 8];
   endfunction : id_char

   ////////////////////////////////////////////////////////////////////////////
   // state shared by the handshakes
   gdi_pkg::gdi_ah_t ah_q, ah_d;
   gdi_pkg::gdi_sh_t sh_q;
   logic listen_q, talk_q, spms_q, rx_full_q, rx_end_q, tx_full_q, tx_eoi_q, id_busy_q, srq_q, eos_en_q;
   logic [7:0] acc_byte_q, rx_data_q, tx_data_q, dio_n_q, settle_q;
   logic acc_atn_q, acc_eoi_q, dio_oe_q, dav_oe_q, eoi_oe_q, nrfd_oe_q, ndac_oe_q, rtl_q;
   logic [2:0] id_idx_q;
   logic [5:0] spoll_q;
   logic [6:0] irq_stat_q, irq_mask_q, ev;
   logic listen_eff, talk_eff, cmd_ev, data_ev, clear_ev, trig_ev, msg_end, rx_ev, sent_ev, rtl_ev;
   logic [6:0] cmd;
   logic is_sp_q, is_id_q;

   assign listen_eff = listen_q | sw.listen_only; // [RULE7]
   assign talk_eff = talk_q | sw.talk_only;
   assign cmd = acc_byte_q[6:0];
   assign cmd_ev = (ah_q == gdi_pkg::AH_ACPT) & acc_atn_q;
   assign data_ev = (ah_q == gdi_pkg::AH_ACPT) & ~acc_atn_q;
   assign clear_ev = cmd_ev & ((cmd == `GDI_CMD_DCL) | ((cmd == `GDI_CMD_SDC) & listen_eff)); // [RULE15]
   assign trig_ev = cmd_ev & (cmd == `GDI_CMD_GET) & listen_eff;
   assign msg_end = acc_eoi_q | (sw.lf_sel & (acc_byte_q == `GDI_CHAR_LF)); // [RULE5]
   assign rx_ev = data_ev & ren; // [RULE9]

   ////////////////////////////////////////////////////////////////////////////
   // acceptor handshake
   always_comb
   begin
      ah_d = ah_q;
      unique case (ah_q)
         gdi_pkg::AH_OFF: if (atn | listen_eff) ah_d = gdi_pkg::AH_IDLE;
         gdi_pkg::AH_IDLE:
            if (!(atn | listen_eff)) ah_d = gdi_pkg::AH_OFF;
            else if (dav & (atn | ~rx_full_q)) ah_d = gdi_pkg::AH_ACPT;
         gdi_pkg::AH_ACPT: ah_d = gdi_pkg::AH_WAIT;
         gdi_pkg::AH_WAIT: if (!dav) ah_d = gdi_pkg::AH_IDLE;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ah_q <= gdi_pkg::AH_OFF;
         nrfd_oe_q <= 1'b0;
         ndac_oe_q <= 1'b0;
         acc_byte_q <= 8'h00;
         acc_atn_q <= 1'b0;
         acc_eoi_q <= 1'b0;
      end
      else
      begin
         ah_q <= ah_d;
         nrfd_oe_q <= ((ah_d == gdi_pkg::AH_IDLE) & ~(atn | ~rx_full_q)) | ah_d[0];
         ndac_oe_q <= ~ah_d[1];
         if (ah_q == gdi_pkg::AH_IDLE && ah_d == gdi_pkg::AH_ACPT)
         begin
            acc_byte_q <= ~bin.dio_n;
            acc_atn_q <= atn;
            acc_eoi_q <= eoi;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // addressing, serial poll, remote and lockout
   always_ff @(posedge aclk)
   begin
      if (!aresetn || ifc) // [RULE8]
      begin
         listen_q <= 1'b0;
         talk_q <= 1'b0;
         spms_q <= 1'b0;
      end
      else if (cmd_ev)
      begin
         if (cmd == `GDI_CMD_UNL) listen_q <= 1'b0;
         else if (addr_ok && cmd == {`GDI_GRP_LISTEN, sw.addr}) listen_q <= 1'b1; // [RULE3]
         if (cmd[6:5] == `GDI_GRP_TALK) talk_q <= addr_ok && cmd[4:0] == sw.addr; // [RULE3]
         if (cmd == `GDI_CMD_SPE) spms_q <= 1'b1; // [RULE2]
         if (cmd == `GDI_CMD_SPD) spms_q <= 1'b0; // [RULE2]
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn || !ren) // [RULE9]
      begin
         remote <= 1'b0;
         panel_lock <= 1'b0;
      end
      else if (cmd_ev)
      begin
         if (addr_ok && cmd == {`GDI_GRP_LISTEN, sw.addr}) remote <= 1'b1;
         if (cmd == `GDI_CMD_LLO) panel_lock <= 1'b1; // [RULE12]
         if (cmd == `GDI_CMD_GTL && listen_eff)
         begin
            remote <= 1'b0; // [RULE13]
            panel_lock <= 1'b0; // [RULE13]
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         listen_ind <= 1'b0;
         talk_ind <= 1'b0;
         sweep_rearm <= 1'b0;
         rtl_q <= 1'b0;
      end
      else
      begin
         listen_ind <= listen_eff & ~ifc; // [RULE1] [RULE8]
         talk_ind <= talk_eff & ~ifc; // [RULE1]
         sweep_rearm <= trig_ev; // [RULE14]
         rtl_q <= sw.rtl_btn;
      end
   end
   assign rtl_ev = sw.rtl_btn & ~rtl_q & sw.talk_only; // [RULE6]

   ////////////////////////////////////////////////////////////////////////////
   // source handshake; serial poll byte before identity before software byte
   always_ff @(posedge aclk)
   begin
      if (!aresetn || !(talk_eff && !atn))
      begin
         sh_q <= gdi_pkg::SH_IDLE;
         dio_n_q <= 8'hff;
         dio_oe_q <= 1'b0;
         dav_oe_q <= 1'b0;
         eoi_oe_q <= 1'b0;
         settle_q <= 8'h00;
         is_sp_q <= 1'b0;
         is_id_q <= 1'b0;
      end
      else
      begin
         unique case (sh_q)
            gdi_pkg::SH_IDLE:
               if (spms_q || id_busy_q || tx_full_q)
               begin
                  is_sp_q <= spms_q;
                  is_id_q <= ~spms_q & id_busy_q;
                  if (spms_q) dio_n_q <= ~{1'b0, srq_q, spoll_q}; // [RULE2]
                  else if (id_busy_q) dio_n_q <= ~id_char(id_idx_q); // [RULE11]
                  else dio_n_q <= ~tx_data_q;
                  eoi_oe_q <= ~spms_q & ~id_busy_q & tx_eoi_q;
                  dio_oe_q <= 1'b1;
                  settle_q <= 8'(`GDI_SETTLE_CYC);
                  sh_q <= gdi_pkg::SH_SETL;
               end
            gdi_pkg::SH_SETL:
               if (settle_q != 8'h00) settle_q <= settle_q - 8'h01;
               else if (!nrfd)
               begin
                  dav_oe_q <= 1'b1;
                  sh_q <= gdi_pkg::SH_DAV;
               end
            gdi_pkg::SH_DAV:
               if (!ndac)
               begin
                  dav_oe_q <= 1'b0;
                  sh_q <= gdi_pkg::SH_DONE;
               end
            gdi_pkg::SH_DONE:
            begin
               dio_oe_q <= 1'b0;
               eoi_oe_q <= 1'b0;
               sh_q <= gdi_pkg::SH_IDLE;
            end
         endcase
      end
   end
   assign sent_ev = (sh_q == gdi_pkg::SH_DAV) & ~ndac & talk_eff & ~atn;

   assign bus_o = '{dio_n: dio_n_q, default: '0};
   assign bus_oe = '{dio_n: {8{dio_oe_q}}, dav_n: dav_oe_q, nrfd_n: nrfd_oe_q, ndac_n: ndac_oe_q,
                     eoi_n: eoi_oe_q, srq_n: srq_q};

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite slave
   logic aw_have_q, w_have_q, wr_fire, ar_hs, aw_have_d, w_have_d, bvalid_d, rvalid_d;
   logic [7:0] waddr_q;
   logic [31:0] wdata_q, wm;
   logic [3:0] wstrb_q;

   assign wr_fire = aw_have_q & w_have_q & ~bvalid;
   assign aw_have_d = (aw_have_q | (awvalid & awready)) & ~wr_fire;
   assign w_have_d = (w_have_q | (wvalid & wready)) & ~wr_fire;
   assign bvalid_d = wr_fire | (bvalid & ~bready);
   assign ar_hs = arvalid & arready;
   assign rvalid_d = ar_hs | (rvalid & ~rready);
   assign wm = wdata_q & {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         {aw_have_q, w_have_q, awready, wready, bvalid, arready, rvalid} <= 7'h00;
         bresp <= `GDI_RESP_OKAY;
         rresp <= `GDI_RESP_OKAY;
         rdata <= 32'h0000_0000;
         waddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end
      else
      begin
         aw_have_q <= aw_have_d;
         w_have_q <= w_have_d;
         bvalid <= bvalid_d;
         rvalid <= rvalid_d;
         awready <= ~aw_have_d & ~bvalid_d;
         wready <= ~w_have_d & ~bvalid_d;
         arready <= ~rvalid_d;
         if (awvalid && awready) waddr_q <= awaddr;
         if (wvalid && wready)
         begin
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (wr_fire) bresp <= reg_hit(waddr_q) ? `GDI_RESP_OKAY : `GDI_RESP_SLVERR;
         if (ar_hs)
         begin
            rresp <= reg_hit(araddr) ? `GDI_RESP_OKAY : `GDI_RESP_SLVERR;
            unique case (araddr)
               `GDI_OFS_CTRL: rdata <= {31'h0, eos_en_q};
               `GDI_OFS_STAT: rdata <= {18'h0, srq_q, sw.addr, rx_full_q, tx_full_q, ren, spms_q,
                                        panel_lock, remote, talk_q, listen_q};
               `GDI_OFS_TXD: rdata <= {23'h0, tx_eoi_q, tx_data_q};
               `GDI_OFS_RXD: rdata <= {23'h0, rx_end_q, rx_data_q};
               `GDI_OFS_SPOLL: rdata <= {26'h0, spoll_q};
               `GDI_OFS_IRQ_STAT: rdata <= {25'h0, irq_stat_q};
               `GDI_OFS_IRQ_MASK: rdata <= {25'h0, irq_mask_q};
               default: rdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // software-visible data, control and interrupt registers
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         eos_en_q <= 1'b0;
         spoll_q <= 6'h00;
         irq_mask_q <= 7'h00;
      end
      else if (wr_fire)
      begin
         if (waddr_q == `GDI_OFS_CTRL && wstrb_q[0]) eos_en_q <= wdata_q[`GDI_CTRL_EOS_EN];
         if (waddr_q == `GDI_OFS_SPOLL && wstrb_q[0]) spoll_q <= wdata_q[5:0];
         if (waddr_q == `GDI_OFS_IRQ_MASK && wstrb_q[0]) irq_mask_q <= wdata_q[6:0];
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn || clear_ev) // [RULE15]
      begin
         tx_full_q <= 1'b0;
         tx_eoi_q <= 1'b0;
         tx_data_q <= 8'h00;
         id_busy_q <= 1'b0;
         id_idx_q <= 3'h0;
      end
      else
      begin
         if (sent_ev && !is_sp_q && !is_id_q) tx_full_q <= 1'b0;
         else if (wr_fire && waddr_q == `GDI_OFS_TXD && wstrb_q[0] && !tx_full_q)
         begin
            tx_full_q <= 1'b1;
            tx_data_q <= wdata_q[7:0];
            tx_eoi_q <= wdata_q[`GDI_TXD_EOI];
         end
         if (sent_ev && is_id_q)
         begin
            id_idx_q <= id_idx_q + 3'h1;
            if (id_idx_q == 3'(`GDI_ID_LEN - 1)) id_busy_q <= 1'b0;
         end
         else if (wr_fire && waddr_q == `GDI_OFS_CTRL && wm[`GDI_CTRL_ID_SEND])
         begin
            id_busy_q <= 1'b1; // [RULE11]
            id_idx_q <= 3'h0;
         end
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rx_full_q <= 1'b0;
         rx_end_q <= 1'b0;
         rx_data_q <= 8'h00;
         srq_q <= `GDI_SRQ_RST; // [RULE10]
      end
      else
      begin
         if (rx_ev)
         begin
            rx_full_q <= 1'b1;
            rx_data_q <= acc_byte_q;
            rx_end_q <= msg_end; // [RULE5]
         end
         else if (ar_hs && araddr == `GDI_OFS_RXD) rx_full_q <= 1'b0;
         if ((sweep_end && eos_en_q) || (wr_fire && waddr_q == `GDI_OFS_CTRL && wm[`GDI_CTRL_SRQ_REQ]))
            srq_q <= 1'b1; // [RULE10]
         else if (sent_ev && is_sp_q) srq_q <= 1'b0;
      end
   end

   assign ev = {sent_ev & ~is_sp_q, ifc, rtl_ev, clear_ev, trig_ev, rx_ev & msg_end, rx_ev};

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_stat_q <= 7'h00;
         irq <= 1'b0;
      end
      else
      begin
         irq_stat_q <= (irq_stat_q & ~((wr_fire && waddr_q == `GDI_OFS_IRQ_STAT) ? wm[6:0] : 7'h00)) | ev;
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_ifc_unaddr: assert property (ifc && !sw.listen_only |=> !listen_q ##1 !listen_ind) // [RULE8]
      else $error("interface clear left device addressed");
   a_ren_local: assert property (!ren |=> !remote && !panel_lock) // [RULE9]
      else $error("remote state kept without remote enable");
   a_srq_boot: assert property ($rose(aresetn) |-> srq_q ##1 bus_oe.srq_n) // [RULE10]
      else $error("no service request after reset");
   a_get_rearm: assert property (trig_ev |=> sweep_rearm ##1 !sweep_rearm) // [RULE14]
      else $error("trigger did not re-arm sweep for one cycle");
   a_clear_flush: assert property (clear_ev |=> !tx_full_q && !id_busy_q && irq_stat_q[`GDI_IRQ_CLEAR]) // [RULE15]
      else $error("device clear left output pending");
   a_llo_lock: assert property (cmd_ev && cmd == `GDI_CMD_LLO && ren |=> panel_lock) // [RULE12]
      else $error("lockout not taken");
   a_gtl_local: assert property (cmd_ev && cmd == `GDI_CMD_GTL && listen_q |=> !remote && !panel_lock) // [RULE13]
      else $error("go to local ignored");
   a_spoll_byte: assert property (sh_q == gdi_pkg::SH_IDLE && spms_q && talk_eff && !atn
                                  |=> dio_n_q == ~{1'b0, $past(srq_q), $past(spoll_q)}) // [RULE2]
      else $error("serial poll byte wrong");
   a_lf_end: assert property (rx_ev && sw.lf_sel && acc_byte_q == `GDI_CHAR_LF
                              |=> rx_end_q && irq_stat_q[`GDI_IRQ_MSG_END]) // [RULE5]
      else $error("line feed did not end message");
   a_mla_listen: assert property (cmd_ev && addr_ok && cmd == {`GDI_GRP_LISTEN, sw.addr} && !ifc
                                  |=> listen_q ##1 listen_ind) // [RULE1] [RULE3]
      else $error("own listen address not taken");
   a_rtl_event: assert property (rtl_ev |=> irq_stat_q[`GDI_IRQ_RTL]) // [RULE6]
      else $error("button press not reported in talk-only");
endmodule : gdi_core

// ===== gdi_core_tb.sv
// self-checking testbench of the instrument bus interface
`timescale 1ns/1ps
`include "gdi_defines.svh"
module gdi_core_tb;
   typedef struct packed {logic [7:0] cmd; logic [3:0] exp;} gdi_row_t;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   gdi_pkg::gdi_bus_in_t bus_i;
   gdi_pkg::gdi_bus_drv_t bus_o;
   gdi_pkg::gdi_bus_drv_t bus_oe;
   gdi_pkg::gdi_sw_t sw_i = '{5'h05, 1'b1, 1'b0, 1'b0, 1'b0};
   logic sweep_end = 1'b0;
   logic listen_ind, talk_ind, remote, panel_lock, sweep_rearm, irq;
   int n_fail = 0;
   int tests_run = 0;
   int n_rearm = 0;
   logic ok;
   logic [31:0] rd;
   logic [1:0] rs;
   logic [7:0] rb;
   // command byte and {listen, talk, lock, remote} after it
   gdi_row_t rows [6] = '{'{8'h25, 4'h9}, '{8'h11, 4'hb}, '{8'h01, 4'h8},
      '{8'h3f, 4'h0}, '{8'h45, 4'h4}, '{8'h23, 4'h4}};
   always #5 aclk = ~aclk;
   always @(posedge aclk) if (sweep_rearm === 1'b1) n_rearm <= n_rearm + 1;
   gdi_core uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
      .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
      .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
      .rvalid(rvalid), .rready(rready), .bus_i(bus_i), .bus_o(bus_o), .bus_oe(bus_oe), .sw_i(sw_i),
      .sweep_end(sweep_end), .listen_ind(listen_ind), .talk_ind(talk_ind), .remote(remote),
      .panel_lock(panel_lock), .sweep_rearm(sweep_rearm), .irq(irq));
   gdi_ctl_model ctl (.aclk(aclk), .bus_o(bus_o), .bus_oe(bus_oe), .bus_i(bus_i));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic stuck(input logic c);
      if (c)
      begin
         n_fail++;
         $display("Error at %0t: handshake timeout", $time);
         tally_and_finish();
      end
   endtask : stuck
   task automatic cmd(input logic [7:0] b);
      ctl.send(1'b1, b, ok);
      stuck(!ok);
      repeat (6) @(posedge aclk);
   endtask : cmd
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      @(posedge aclk);
      stuck(n == 50);
   endtask : axi_wr
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50; n++)
      begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      @(posedge aclk);
      stuck(n == 50);
   endtask : axi_rd
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (4) @(posedge aclk);
      chk(32'(bus_oe.srq_n), 32'h1);
      chk(32'(irq), 32'h0);
      axi_rd(`GDI_OFS_STAT, rd, rs);
      chk(32'(rd[13:8]), 32'h25);
      axi_rd(8'h1c, rd, rs);
      chk(32'(rs), 32'(`GDI_RESP_SLVERR));
      chk(rd, 32'h0);
      axi_wr(`GDI_OFS_IRQ_MASK, 32'h1 << `GDI_IRQ_TRIG);
      foreach (rows[i])
      begin
         cmd(rows[i].cmd);
         chk(32'({listen_ind, talk_ind, panel_lock, remote}), 32'(rows[i].exp));
      end
      cmd(8'h25);
      cmd({1'b0, `GDI_CMD_GET});
      chk(n_rearm, 1);
      chk(32'(irq), 32'h1);
      axi_wr(`GDI_OFS_IRQ_STAT, 32'h1 << `GDI_IRQ_TRIG);
      repeat (3) @(posedge aclk);
      chk(32'(irq), 32'h0);
      ctl.send(1'b0, `GDI_CHAR_LF, ok);
      stuck(!ok);
      axi_rd(`GDI_OFS_RXD, rd, rs);
      chk(rd, 32'h10a);
      cmd(8'h3f);
      cmd({1'b0, `GDI_CMD_SPE});
      ctl.recv(rb, ok);
      stuck(!ok);
      chk(32'(rb), 32'h40);
      cmd({1'b0, `GDI_CMD_SPD});
      chk(32'(bus_oe.srq_n), 32'h0);
      axi_wr(`GDI_OFS_CTRL, 32'h3);
      ctl.recv(rb, ok);
      stuck(!ok);
      chk(32'(rb), 32'(`GDI_ID_PREFIX >> 56));
      cmd({1'b0, `GDI_CMD_DCL});
      ctl.recv(rb, ok);
      chk(32'(ok), 32'h0);
      sweep_end <= 1'b1;
      @(posedge aclk);
      sweep_end <= 1'b0;
      repeat (2) @(posedge aclk);
      chk(32'(bus_oe.srq_n), 32'h1);
      ctl.ren_q <= 1'b1;
      repeat (6) @(posedge aclk);
      chk(32'(remote), 32'h0);
      ctl.ifc_q <= 1'b0;
      repeat (4) @(posedge aclk);
      ctl.ifc_q <= 1'b1;
      repeat (6) @(posedge aclk);
      chk(32'({listen_ind, talk_ind}), 32'h0);
      sw_i.listen_only <= 1'b1;
      repeat (6) @(posedge aclk);
      chk(32'(listen_ind), 32'h1);
      sw_i.talk_only <= 1'b1;
      repeat (4) @(posedge aclk);
      sw_i.rtl_btn <= 1'b1;
      repeat (6) @(posedge aclk);
      axi_rd(`GDI_OFS_IRQ_STAT, rd, rs);
      chk(32'(rd[`GDI_IRQ_RTL]), 32'h1);
      tally_and_finish();
   end
   initial
   begin
      repeat (100000) @(posedge aclk);
      stuck(1'b1);
   end
endmodule : gdi_core_tb

// ===== gdi_ctl_model.sv
// bus controller model that faces the instrument bus interface
`timescale 1ns/1ps
module gdi_ctl_model
(
   input logic aclk,
   input gdi_pkg::gdi_bus_drv_t bus_o,
   input gdi_pkg::gdi_bus_drv_t bus_oe,
   output gdi_pkg::gdi_bus_in_t bus_i
);
   logic [7:0] dio_q = 8'hff;
   logic dav_q = 1'b1;
   logic atn_q = 1'b1;
   logic ifc_q = 1'b1;
   logic ren_q = 1'b0;
   logic nrfd_q = 1'b1;
   logic ndac_q = 1'b1;
   ////////////////////////////////////////////////////////////////////////////////
   // wired-and of both parties on dio, dav, nrfd and ndac; released lines go high through the pull-ups
   assign bus_i.dio_n = dio_q & (bus_o.dio_n | ~bus_oe.dio_n);
   assign bus_i.dav_n = dav_q & (bus_o.dav_n | ~bus_oe.dav_n);
   assign bus_i.nrfd_n = nrfd_q & (bus_o.nrfd_n | ~bus_oe.nrfd_n);
   assign bus_i.ndac_n = ndac_q & (bus_o.ndac_n | ~bus_oe.ndac_n);
   assign bus_i.eoi_n = bus_o.eoi_n | ~bus_oe.eoi_n;
   assign bus_i.atn_n = atn_q;
   assign bus_i.ifc_n = ifc_q;
   assign bus_i.ren_n = ren_q;
   ////////////////////////////////////////////////////////////////////////////////
   // source handshake of one byte; ok goes low on a stuck handshake
   task automatic send(input logic atn, input logic [7:0] b, output logic ok);
      int n;
      int m;
      dio_q <= ~b;
      atn_q <= ~atn;
      nrfd_q <= 1'b1;
      repeat (4) @(posedge aclk);
      for (n = 0; n < 400 && bus_i.nrfd_n !== 1'b1; n++) @(posedge aclk);
      dav_q <= 1'b0;
      @(posedge aclk);
      for (m = 0; m < 400 && bus_i.ndac_n !== 1'b1; m++) @(posedge aclk);
      dav_q <= 1'b1;
      @(posedge aclk);
      dio_q <= 8'hff;
      atn_q <= 1'b1;
      ok = (n < 400) && (m < 400);
   endtask : send
   ////////////////////////////////////////////////////////////////////////////////
   // acceptor handshake of one byte; ok goes low when no byte comes
   task automatic recv(output logic [7:0] b, output logic ok);
      int n;
      int m;
      b = 8'h00;
      m = 0;
      nrfd_q <= 1'b1;
      ndac_q <= 1'b0;
      @(posedge aclk);
      for (n = 0; n < 400 && bus_i.dav_n !== 1'b0; n++) @(posedge aclk);
      if (n < 400)
      begin
         b = ~bus_i.dio_n;
         nrfd_q <= 1'b0;
         ndac_q <= 1'b1;
         for (m = 0; m < 400 && bus_i.dav_n !== 1'b1; m++) @(posedge aclk);
      end
      else
         ndac_q <= 1'b1;
      ok = (n < 400) && (m < 400);
   endtask : recv
endmodule : gdi_ctl_model

// ===== gdi_defines.svh
// offsets, field positions, reset values, bus codes and timing of the instrument bus interface
`ifndef GDI_DEFINES_SVH
`define GDI_DEFINES_SVH

`define GDI_OFS_CTRL 8'h00
`define GDI_OFS_STAT 8'h04
`define GDI_OFS_TXD 8'h08
`define GDI_OFS_RXD 8'h0c
`define GDI_OFS_SPOLL 8'h10
`define GDI_OFS_IRQ_STAT 8'h14
`define GDI_OFS_IRQ_MASK 8'h18

`define GDI_CTRL_EOS_EN 0
`define GDI_CTRL_ID_SEND 1
`define GDI_CTRL_SRQ_REQ 2
`define GDI_TXD_EOI 8
`define GDI_RXD_END 8

`define GDI_IRQ_RX 0
`define GDI_IRQ_MSG_END 1
`define GDI_IRQ_TRIG 2
`define GDI_IRQ_CLEAR 3
`define GDI_IRQ_RTL 4
`define GDI_IRQ_IFC 5
`define GDI_IRQ_TX_DONE 6
`define GDI_IRQ_W 7

`define GDI_RESP_OKAY 2'h0
`define GDI_RESP_SLVERR 2'h2

`define GDI_SRQ_RST 1'b1
`define GDI_ADDR_NONE 5'h1f
`define GDI_CMD_GTL 7'h01
`define GDI_CMD_SDC 7'h04
`define GDI_CMD_GET 7'h08
`define GDI_CMD_LLO 7'h11
`define GDI_CMD_DCL 7'h14
`define GDI_CMD_SPE 7'h18
`define GDI_CMD_SPD 7'h19
`define GDI_CMD_UNL 7'h3f
`define GDI_GRP_LISTEN 2'h1
`define GDI_GRP_TALK 2'h2
`define GDI_CHAR_LF 8'h0a

`define GDI_CLK_MHZ 100
`define GDI_T_SETTLE_NS 2000
`define GDI_SETTLE_CYC ((`GDI_T_SETTLE_NS * `GDI_CLK_MHZ + 999) / 1000)

// identity prefix value is arbitrary
`define GDI_ID_PREFIX 64'h4944_2058_595a_2f30
`define GDI_ID_LEN 8

`endif

// ===== gdi_pkg.sv
// types shared by the instrument bus interface
package gdi_pkg;

   typedef struct packed {
      logic [7:0] dio_n;
      logic dav_n;
      logic nrfd_n;
      logic ndac_n;
      logic eoi_n;
      logic atn_n;
      logic ifc_n;
      logic ren_n;
   } gdi_bus_in_t;

   typedef struct packed {
      logic [7:0] dio_n;
      logic dav_n;
      logic nrfd_n;
      logic ndac_n;
      logic eoi_n;
      logic srq_n;
   } gdi_bus_drv_t;

   typedef struct packed {
      logic [4:0] addr;
      logic lf_sel;
      logic talk_only;
      logic listen_only;
      logic rtl_btn;
   } gdi_sw_t;

   typedef enum logic [1:0] {AH_IDLE = 2'b00, AH_ACPT = 2'b01, AH_WAIT = 2'b11, AH_OFF = 2'b10} gdi_ah_t;
   typedef enum logic [1:0] {SH_IDLE = 2'b00, SH_SETL = 2'b01, SH_DAV = 2'b11, SH_DONE = 2'b10} gdi_sh_t;

endpackage : gdi_pkg

// ===== gdi_sync.sv
// two flip-flop synchroniser for pins and switches
`timescale 1ns/1ps
module gdi_sync
#(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
)
(
   input logic aclk,
   input logic aresetn,
   input logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         meta_q <= INIT;
         q <= INIT;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : gdi_sync
